// *** hw/cse_pin_sync.sv ***
/*
 * cse_pin_sync: three-stage synchroniser with agreement filter for socket pins.
 * Assumes the pins are asynchronous to ref_clk and that rst_b is already the
 * released, synchronous copy of the block reset.
 */
`timescale 1ns/1ns

module cse_pin_sync
#(
	parameter int               WIDTH       = 3,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] stable_out
);
	import cse_pkg::*;

	// a zero-width synchroniser has nothing to carry
	if (WIDTH < 1)
	begin : g_bad_width
		$error("synchroniser width must be at least one");
	end

	logic [WIDTH-1:0] stage_one;
	logic [WIDTH-1:0] stage_two;
	logic [WIDTH-1:0] stage_three;
	logic [WIDTH-1:0] next_stable;

	// a bit only moves once the second and third stages agree
	assign next_stable = (stage_two ~^ stage_three) & stage_three
		| ~(stage_two ~^ stage_three) & stable_out;

	// stage_one feeds stage_two alone, so metastability never reaches logic
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stage_one   <= RESET_VALUE;
			stage_two   <= RESET_VALUE;
			stage_three <= RESET_VALUE;
			stable_out  <= RESET_VALUE;
		end
		else
		begin
			stage_one   <= pin_in;
			stage_two   <= stage_one;
			stage_three <= stage_two;
			stable_out  <= next_stable;
		end
	end

endmodule : cse_pin_sync

// *** hw/cse_pkg.sv ***
/*
 * cse_pkg: shared constants and types for the card socket event and mask block.
 * Assumes a 32-bit host data path and a socket register window of 4 KB that
 * starts at a base address supplied by the bridge configuration logic.
 */
package cse_pkg;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef logic [31:0] cse_word_type;
	typedef logic [3:0]  cse_flag_type;
	typedef logic [3:0]  cse_lane_type;

	// ****************************************************************
	// window geometry
	// ****************************************************************
	localparam int           CSE_WINDOW_BITS = 12;

	// ****************************************************************
	// register byte offsets inside the socket window
	// ****************************************************************
	localparam logic [11:0]  CSE_OFS_CHANGE_FLAGS   = 12'h000;
	localparam logic [11:0]  CSE_OFS_CHANGE_ENABLES = 12'h004;
	localparam logic [11:0]  CSE_OFS_LIVE_STATUS    = 12'h008;
	localparam logic [11:0]  CSE_OFS_EVENT_INJECTOR = 12'h00c;
	localparam logic [11:0]  CSE_OFS_CONTROL_WORD   = 12'h010;
	localparam logic [11:0]  CSE_OFS_POWER_MGMT     = 12'h020;

	// ****************************************************************
	// field positions, shared by flags, enables, injector and live status
	// ****************************************************************
	localparam int           CSE_BIT_POWER      = 3;
	localparam int           CSE_BIT_DETECT_TWO = 2;
	localparam int           CSE_BIT_DETECT_ONE = 1;
	localparam int           CSE_BIT_CARD_STS   = 0;
	localparam int           CSE_FLAG_COUNT     = 4;

	// card detect enable is a two-bit field; only the all-ones pattern enables
	localparam logic [1:0]   CSE_DETECT_ENABLE_ON = 2'b11;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam cse_flag_type CSE_FLAGS_RESET     = 4'h0;
	localparam cse_flag_type CSE_ENABLES_RESET   = 4'h0;
	localparam cse_word_type CSE_CONTROL_RESET   = 32'h0000_0000;
	localparam cse_word_type CSE_POWER_RESET     = 32'h0000_0000;
	localparam cse_word_type CSE_LIVE_FIXED_BITS = 32'h3000_0000;
	localparam cse_word_type CSE_READ_IDLE       = 32'h0000_0000;

	// pin synchroniser idle levels: detect lines idle high, status line low
	localparam logic [2:0]   CSE_PIN_IDLE = 3'b110;

endpackage : cse_pkg

// *** hw/cse_socket_event_mask.sv ***
/*
 * cse_socket_event_mask: socket status-change flags, enables and the
 * status-change interrupt, with the socket register window on the host port.
 * Assumes a single-cycle host access port already qualified as a memory
 * access, a socket base address from the configuration space, socket power
 * state and card type from on-chip logic, and raw card pins from the socket.
 */
`timescale 1ns/1ns

module cse_socket_event_mask
#(
	parameter int CONTROL_WIDTH    = 32,
	parameter int POWER_MGMT_WIDTH = 32
)
(
	input  wire logic                         ref_clk,
	input  wire logic                         rst_b,
	input  wire cse_pkg::cse_word_type        socket_base,
	input  wire cse_pkg::cse_word_type        host_addr,
	input  wire logic                         host_rd,
	input  wire logic                         host_wr,
	input  wire cse_pkg::cse_lane_type        host_be,
	input  wire cse_pkg::cse_word_type        host_wdata,
	output cse_pkg::cse_word_type             host_rdata,
	output logic                              host_rd_valid,
	input  wire logic                         card_detect_line_one_b,
	input  wire logic                         card_detect_line_two_b,
	input  wire logic                         card_status_line,
	input  wire logic                         socket_powered_state,
	input  wire logic                         card_is_cardbus,
	output logic                              status_change_interrupt,
	output logic [CONTROL_WIDTH-1:0]          socket_control_word,
	output logic [POWER_MGMT_WIDTH-1:0]       socket_power_management
);
	import cse_pkg::*;

	// ****************************************************************
	// parameter checks
	// ****************************************************************
	// the read path zero-extends both words, so neither may exceed the bus
	if (CONTROL_WIDTH < 8 || CONTROL_WIDTH > 32 || POWER_MGMT_WIDTH < 8
		|| POWER_MGMT_WIDTH > 32)
	begin : g_bad_width
		$error("control and power management widths must lie between 8 and 32");
	end

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic [1:0]                  rst_pipe;
	logic                        rst_sync_b;
	logic [2:0]                  pin_stable;
	logic                        detect_one_state, detect_two_state, card_status_state;
	logic                        power_prev, detect_one_prev;
	logic                        detect_two_prev, card_status_prev;
	logic                        window_hit;
	logic [11:0]                 reg_offset;
	logic                        hit_flags, hit_enables, hit_live;
	logic                        hit_injector, hit_control, hit_power;
	logic                        wr_flags, wr_enables, wr_injector, wr_control, wr_power;
	logic                        power_change, detect_one_change, detect_two_change;
	logic                        card_status_rise, card_status_fall, card_status_change;
	cse_flag_type                status_events, clear_mask, inject_mask;
	cse_flag_type                change_flags, next_change_flags;
	cse_flag_type                change_enables, next_change_enables, gated_flags;
	logic                        detect_enabled, next_interrupt;
	cse_word_type                live_word, control_read, power_read, read_word;
	logic [CONTROL_WIDTH-1:0]    next_control;
	logic [POWER_MGMT_WIDTH-1:0] next_power;

	// ****************************************************************
	// reset release
	// ****************************************************************
	// assertion is immediate, release waits two edges so no flop sees a runt
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			rst_pipe <= 2'b00;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end
	assign rst_sync_b = rst_pipe[1];

	// ****************************************************************
	// socket pin synchronisation
	// ****************************************************************
	// detect lines are active low at the pin; idle high means no card
	cse_pin_sync
	#(
		.WIDTH       (3),
		.RESET_VALUE (CSE_PIN_IDLE)
	)
	u_pin_sync
	(
		.ref_clk    (ref_clk),
		.rst_b      (rst_sync_b),
		.pin_in     ({card_detect_line_two_b, card_detect_line_one_b, card_status_line}),
		.stable_out (pin_stable)
	);

	assign detect_two_state  = ~pin_stable[2];
	assign detect_one_state  = ~pin_stable[1];
	assign card_status_state = pin_stable[0];

	// ****************************************************************
	// change detection
	// ****************************************************************
	// previous values start from the idle state, so a card still present
	// when reset ends shows up as a change straight away
	always_ff @(posedge ref_clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			power_prev       <= 1'b0;
			detect_one_prev  <= 1'b0;
			detect_two_prev  <= 1'b0;
			card_status_prev <= 1'b0;
		end
		else
		begin
			power_prev       <= socket_powered_state;
			detect_one_prev  <= detect_one_state;
			detect_two_prev  <= detect_two_state;
			card_status_prev <= card_status_state;
		end
	end

	// edges only; the new level itself is never stored in a flag
	assign power_change       = socket_powered_state ^ power_prev;
	assign detect_one_change  = detect_one_state ^ detect_one_prev;
	assign detect_two_change  = detect_two_state ^ detect_two_prev;
	assign card_status_rise   = card_status_state & ~card_status_prev;
	assign card_status_fall   = ~card_status_state & card_status_prev;
	// cardbus cards flag the rising edge only, 16-bit cards flag both
	assign card_status_change = card_status_rise
		| (card_status_fall & ~card_is_cardbus);

	assign status_events = {power_change, detect_two_change, detect_one_change,
		card_status_change};

	// ****************************************************************
	// host address decode
	// ****************************************************************
	// the window is claimed only when the upper address matches the base
	assign window_hit   = host_addr[31:CSE_WINDOW_BITS] == socket_base[31:CSE_WINDOW_BITS];
	assign reg_offset   = host_addr[CSE_WINDOW_BITS-1:0];
	assign hit_flags    = window_hit && reg_offset == CSE_OFS_CHANGE_FLAGS;
	assign hit_enables  = window_hit && reg_offset == CSE_OFS_CHANGE_ENABLES;
	assign hit_live     = window_hit && reg_offset == CSE_OFS_LIVE_STATUS;
	assign hit_injector = window_hit && reg_offset == CSE_OFS_EVENT_INJECTOR;
	assign hit_control  = window_hit && reg_offset == CSE_OFS_CONTROL_WORD;
	assign hit_power    = window_hit && reg_offset == CSE_OFS_POWER_MGMT;

	assign wr_flags    = host_wr && hit_flags;
	assign wr_enables  = host_wr && hit_enables;
	assign wr_injector = host_wr && hit_injector;
	assign wr_control  = host_wr && hit_control;
	assign wr_power    = host_wr && hit_power;

	// ****************************************************************
	// change flags
	// ****************************************************************
	// all defined bits live in byte lane 0
	assign clear_mask  = (wr_flags && host_be[0]) ? host_wdata[3:0] : 4'h0;
	assign inject_mask = (wr_injector && host_be[0]) ? host_wdata[3:0] : 4'h0;

	// set beats clear so an edge landing on a write-one-to-clear is kept;
	// enables take no part here, they only gate the interrupt
	assign next_change_flags = (change_flags & ~clear_mask) | status_events
		| inject_mask;

	always_ff @(posedge ref_clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			change_flags <= CSE_FLAGS_RESET;
		else
			change_flags <= next_change_flags;
	end

	// ****************************************************************
	// change enables
	// ****************************************************************
	assign next_change_enables = (wr_enables && host_be[0]) ? host_wdata[3:0]
		: change_enables;

	always_ff @(posedge ref_clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			change_enables <= CSE_ENABLES_RESET;
		else
			change_enables <= next_change_enables;
	end

	// ****************************************************************
	// status-change interrupt
	// ****************************************************************
	// the mixed detect patterns 01 and 10 are treated as disabled
	assign detect_enabled = change_enables[2:1] == CSE_DETECT_ENABLE_ON;
	assign gated_flags[CSE_BIT_POWER]      = change_flags[CSE_BIT_POWER]
		& change_enables[CSE_BIT_POWER];
	assign gated_flags[CSE_BIT_DETECT_TWO] = change_flags[CSE_BIT_DETECT_TWO]
		& detect_enabled;
	assign gated_flags[CSE_BIT_DETECT_ONE] = change_flags[CSE_BIT_DETECT_ONE]
		& detect_enabled;
	assign gated_flags[CSE_BIT_CARD_STS]   = change_flags[CSE_BIT_CARD_STS]
		& change_enables[CSE_BIT_CARD_STS];
	// a level, so a flag left pending when enabled still interrupts
	assign next_interrupt = |gated_flags;

	// registered to keep the pin free of decode glitches, at one cycle of lag
	always_ff @(posedge ref_clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			status_change_interrupt <= 1'b0;
		else
			status_change_interrupt <= next_interrupt;
	end

	// ****************************************************************
	// control and power management words
	// ****************************************************************
	// byte-lane writes; contents steer logic outside this block
	for (genvar i = 0; i < 32; i++)
	begin : g_lane_bits
		if (i < CONTROL_WIDTH)
		begin : g_ctrl
			assign next_control[i] = (wr_control && host_be[i/8]) ? host_wdata[i]
				: socket_control_word[i];
		end
		if (i < POWER_MGMT_WIDTH)
		begin : g_pwr
			assign next_power[i] = (wr_power && host_be[i/8]) ? host_wdata[i]
				: socket_power_management[i];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			socket_control_word     <= CSE_CONTROL_RESET[CONTROL_WIDTH-1:0];
			socket_power_management <= CSE_POWER_RESET[POWER_MGMT_WIDTH-1:0];
		end
		else
		begin
			socket_control_word     <= next_control;
			socket_power_management <= next_power;
		end
	end

	// ****************************************************************
	// read path
	// ****************************************************************
	// live status carries the current levels the flags only hint at
	assign live_word = CSE_LIVE_FIXED_BITS | {28'h000_0000, socket_powered_state,
		detect_two_state, detect_one_state, card_status_state};

	// narrower storage words are zero-extended on purpose to the bus width
	assign control_read = cse_word_type'(socket_control_word);
	assign power_read   = cse_word_type'(socket_power_management);

	// injector and the reserved gap read as zero; upper flag bits too
	assign read_word = hit_flags   ? {28'h000_0000, change_flags}
		: hit_enables ? {28'h000_0000, change_enables}
		: hit_live    ? live_word
		: hit_control ? control_read
		: hit_power   ? power_read
		: CSE_READ_IDLE;

	always_ff @(posedge ref_clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			host_rdata    <= CSE_READ_IDLE;
			host_rd_valid <= 1'b0;
		end
		else
		begin
			host_rdata    <= (host_rd && window_hit) ? read_word : CSE_READ_IDLE;
			host_rd_valid <= host_rd && window_hit;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb_main @(posedge ref_clk); endclocking
	default disable iff (!rst_sync_b);

	sequence s_power_pending;
		change_flags[CSE_BIT_POWER] && change_enables[CSE_BIT_POWER];
	endsequence
	sequence s_power_enable_write;
		wr_enables && host_be[0] && host_wdata[CSE_BIT_POWER];
	endsequence
	power_change_sets_a: assert property (power_change |=> change_flags[3])
		else $error("power change did not set its flag");
	detect_change_sets_a: assert property (
		detect_one_change && detect_two_change |=> change_flags[2:1] == 2'b11)
		else $error("detect change did not set both flags");
	write_one_clears_a: assert property (
		wr_flags && host_be[0] && host_wdata[1] && !detect_one_change
		|=> !change_flags[1])
		else $error("write one did not clear detect one flag");
	write_zero_keeps_a: assert property (
		wr_flags && host_be[0] && !host_wdata[3] && change_flags[3] |=> change_flags[3])
		else $error("write zero cleared power flag");
	injector_sets_flag_a: assert property (
		wr_injector && host_be[0] && host_wdata[0] |=> change_flags[0])
		else $error("injector write did not set card status flag");
	cardbus_rise_only_a: assert property (
		card_is_cardbus && card_status_fall && !change_flags[0] && !inject_mask[0]
		|=> !change_flags[0])
		else $error("cardbus falling edge set card status flag");
	sixteen_bit_fall_a: assert property (
		!card_is_cardbus && card_status_fall |=> change_flags[0])
		else $error("16-bit falling edge missed");
	mask_no_block_a: assert property (
		card_status_rise && change_enables == 4'h0 |=> change_flags[0])
		else $error("flag blocked while enables clear");
	reserved_reads_zero_a: assert property (
		host_rd && (hit_flags || hit_enables)
		|=> host_rd_valid && host_rdata[31:4] == 28'h000_0000)
		else $error("reserved flag or enable bits read nonzero");
	live_read_level_a: assert property (
		host_rd && hit_live |=> host_rdata[3] == $past(socket_powered_state))
		else $error("live status read wrong power level");
	power_write_lands_a: assert property (
		wr_power && host_be[0] |=> socket_power_management[7:0] == $past(host_wdata[7:0]))
		else $error("power management write lost");
	pending_raises_irq_a: assert property (s_power_pending |=> status_change_interrupt)
		else $error("pending enabled flag gave no interrupt");
	late_enable_irq_a: assert property (
		s_power_enable_write ##1 change_flags[3] |=> status_change_interrupt)
		else $error("flag left set gave no interrupt after enable");
	gated_quiet_a: assert property ((change_flags & change_enables) == 4'h0
		|=> !status_change_interrupt)
		else $error("interrupt without enabled flag");
	detect_partial_off_a: assert property (
		change_enables[2:1] != 2'b11 && !(change_flags[3] && change_enables[3])
		&& !(change_flags[0] && change_enables[0]) |=> !status_change_interrupt)
		else $error("partial detect enable raised interrupt");

endmodule : cse_socket_event_mask

// *** sim/cse_socket_model.sv ***
/* cse_socket_model: card socket pins as the bridge sees them.
   assumes the bench drives insert and status_pin off the clock edge. */
`timescale 1ns/1ns
module cse_socket_model
(
	input  wire logic insert,
	input  wire logic status_pin,
	output logic      card_detect_line_one_b,
	output logic      card_detect_line_two_b,
	output logic      card_status_line
);
	// both detect pins go low together once a card is seated
	assign card_detect_line_one_b = !insert;
	assign card_detect_line_two_b = !insert;
	// pull-down on the status pin, so an empty socket reads low
	assign card_status_line = insert & status_pin;
endmodule : cse_socket_model

// *** sim/tb.sv ***
/* tb: self-checking bench for the socket flags and enables.
   assumes one 25 MHz clock and inputs driven at the falling edge. */
`timescale 1ns/1ns
module tb;
	import cse_pkg::*;
	logic         ref_clk = 0, rst_b = 0, host_rd = 0, host_wr = 0;
	logic         pwr = 0, cb = 0, ins = 0, sts = 0;
	logic         rd_valid, irq, cd1_b, cd2_b, cst;
	cse_word_type base = 32'h4000_0000, addr = '0, wdata = '0, rdata;
	cse_lane_type be = 4'h0;
	cse_word_type ctl, pm;
	int           mismatches = 0, cmp_count = 0;
	// register rows: offset, written word, word read back
	logic [11:0]  ofs [5] = '{12'h004, 12'h010, 12'h020, 12'h014, 12'h004};
	cse_word_type wd [5] = '{32'hffff_ffff, 32'h1234_5678, 32'ha5a5_a5a5,
		32'hffff_ffff, 32'h0000_0000};
	cse_word_type rx [5] = '{32'h0000_000f, 32'h1234_5678, 32'ha5a5_a5a5,
		32'h0000_0000, 32'h0000_0000};

	always #20 ref_clk = ~ref_clk;

	cse_socket_model sock_u (.insert(ins), .status_pin(sts),
		.card_detect_line_one_b(cd1_b), .card_detect_line_two_b(cd2_b),
		.card_status_line(cst));

	cse_socket_event_mask dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
		.socket_base(base), .host_addr(addr), .host_rd(host_rd),
		.host_wr(host_wr), .host_be(be), .host_wdata(wdata),
		.host_rdata(rdata), .host_rd_valid(rd_valid),
		.card_detect_line_one_b(cd1_b), .card_detect_line_two_b(cd2_b),
		.card_status_line(cst), .socket_powered_state(pwr),
		.card_is_cardbus(cb), .status_change_interrupt(irq),
		.socket_control_word(ctl), .socket_power_management(pm));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc

	// one-cycle write; an idle edge first, so strobes never toggle twice at once
	task automatic wr(input logic [11:0] o, input cse_word_type d);
		@(negedge ref_clk);
		addr = base | o;
		wdata = d;
		be = 4'hf;
		host_wr = 1;
		@(negedge ref_clk) host_wr = 0;
	endtask : wr

	// answer is registered, so it stands at the following falling edge
	task automatic rd(input logic [11:0] o, input cse_word_type e);
		@(negedge ref_clk);
		addr = base | o;
		host_rd = 1;
		@(negedge ref_clk) host_rd = 0;
		chk({31'h0, rd_valid}, 32'h1);
		chk(rdata, e);
	endtask : rd

	task give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	// watchdog: whole sequence needs well under 3000 cycles
	initial
	begin
		#(40 * 3000);
		mismatches++;
		give_verdict();
	end

	initial
	begin
		cyc(10);
		rst_b = 1;
		cyc(4);
		rd(12'h000, 32'h0);
		rd(12'h004, 32'h0);
		rd(12'h008, 32'h3000_0000);
		for (int i = 0; i < 5; i++)
		begin
			wr(ofs[i], wd[i]);
			rd(ofs[i], rx[i]);
		end
		cyc(1);
		addr = 32'h5000_0000;
		host_rd = 1;
		@(negedge ref_clk) host_rd = 0;
		chk({31'h0, rd_valid}, 32'h0);
		chk(ctl, 32'h1234_5678);
		chk(pm, 32'ha5a5_a5a5);
		$display("register rows done");
		wr(12'h00c, 32'h0000_000f);
		rd(12'h000, 32'h0000_000f);
		wr(12'h000, 32'h0000_0005);
		rd(12'h000, 32'h0000_000a);
		wr(12'h000, 32'h0000_0000);
		rd(12'h000, 32'h0000_000a);
		wr(12'h000, 32'h0000_000f);
		pwr = 1;
		cyc(3);
		rd(12'h000, 32'h0000_0008);
		chk({31'h0, irq}, 32'h0);
		wr(12'h004, 32'h0000_0008);
		cyc(2);
		chk({31'h0, irq}, 32'h1);
		wr(12'h000, 32'h0000_0008);
		cyc(2);
		chk({31'h0, irq}, 32'h0);
		$display("flag and power tests done");
		ins = 1;
		cyc(10);
		rd(12'h000, 32'h0000_0006);
		wr(12'h004, 32'h0000_0002);
		cyc(2);
		chk({31'h0, irq}, 32'h0);
		wr(12'h004, 32'h0000_0006);
		cyc(2);
		chk({31'h0, irq}, 32'h1);
		wr(12'h000, 32'h0000_000f);
		wr(12'h004, 32'h0000_0001);
		$display("detect tests done");
		// first pass is a CardBus card, second a 16-bit card
		for (int k = 0; k < 2; k++)
		begin
			cb = (k == 0);
			sts = 1;
			cyc(8);
			rd(12'h000, 32'h0000_0001);
			chk({31'h0, irq}, 32'h1);
			wr(12'h000, 32'h0000_0001);
			sts = 0;
			cyc(8);
			rd(12'h000, {31'h0, k[0]});
			wr(12'h000, 32'h0000_0001);
		end
		$display("card status tests done");
		// leave flags and the interrupt up so the reset below has work to do
		wr(12'h00c, 32'h0000_000f);
		cyc(2);
		chk({31'h0, irq}, 32'h1);
		rst_b = 0;
		sts = 1;
		cyc(2);
		chk({31'h0, irq}, 32'h0);
		rst_b = 1;
		cyc(12);
		// power, both detects and the raised status line all count as changes
		rd(12'h000, 32'h0000_000f);
		$display("second reset done");
		give_verdict();
	end
endmodule : tb
